//--- hw/cdf_map.svh
/*
 * Constants of the clock divider and freeze block: divider half periods,
 * freeze bit positions, reset values, controller register map and serial timing.
 * Assumes inclusion by the package and the design files of this block only.
 */
`ifndef CDF_MAP_SVH
`define CDF_MAP_SVH

// ==========================================================================
// Divider half periods, five bits per select code, code 0 in the low bits
`define CDF_HALF_A {5'h06, 5'h04, 5'h03, 5'h02}
`define CDF_HALF_B {5'h05, 5'h04, 5'h03, 5'h02}
`define CDF_HALF_C {5'h04, 5'h03, 5'h02, 5'h01}
`define CDF_HALF_F {5'h0a, 5'h08, 5'h06, 5'h04, 5'h05, 5'h04, 5'h03, 5'h02}
`define CDF_HALF_W 5
`define CDF_LCM_STEPS 12

// ==========================================================================
// Freeze word layout, in transmission order from bit 0
`define CDF_FRZ_W 12
`define CDF_FRZ_A 0
`define CDF_FRZ_B 4
`define CDF_FRZ_C 8
`define CDF_FRZ_MARK 11
`define CDF_FRZ_RESET 12'hfff
`define CDF_FRZ_LAST 4'hb

// ==========================================================================
// Controller registers and serial timing
`define CDF_ADDR_WORD 12'h000
`define CDF_ADDR_STAT 12'h004
`define CDF_STAT_BUSY 0
`define CDF_STAT_WORD 16
`define CDF_SER_HALF 8'h04
`define CDF_TX_DONE 4'hc

`endif

//--- hw/cdf_pkg.sv
/*
 * Types shared by both ends of the clock divider and freeze block.
 * Assumes cdf_map.svh is on the include path.
 */
`include "cdf_map.svh"

package cdf_pkg;

    // ==========================================================================
    // Scalar types
    typedef logic [1:0] cdf_sel2_t;
    typedef logic [2:0] cdf_sel3_t;
    typedef logic [4:0] cdf_cnt_t;
    typedef logic [`CDF_FRZ_W-1:0] cdf_frz_t;

    // ==========================================================================
    // State machines
    typedef enum logic [1:0] {
        RX_IDLE = 2'b01,
        RX_BITS = 2'b10
    } cdf_rx_e;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_START = 3'b010,
        TX_BITS = 3'b100
    } cdf_tx_e;

    // ==========================================================================
    // Whole state of each end
    typedef struct packed {
        logic serClkPrev;
        cdf_rx_e rxState;
        cdf_frz_t rxShift;
        logic [3:0] rxCount;
        cdf_frz_t freezeEnable;
        cdf_frz_t frozen;
        logic halfStage;
        cdf_cnt_t cntA;
        cdf_cnt_t cntB;
        cdf_cnt_t cntC;
        cdf_cnt_t cntF;
        cdf_cnt_t cntSync;
        logic [3:0] bankOne;
        logic [3:0] bankTwo;
        logic [3:0] bankThree;
        logic loopReturn;
        logic marker;
        logic outFloat;
        logic refTick;
    } cdf_dev_s;

    parameter cdf_dev_s CDF_DEV_RESET = '{
        rxState: RX_IDLE,
        freezeEnable: `CDF_FRZ_RESET,
        marker: 1'b1,
        outFloat: 1'b1,
        default: '0
    };

    typedef struct packed {
        logic [7:0] divCnt;
        logic serClk;
        logic data;
        cdf_tx_e txState;
        cdf_frz_t txShift;
        logic [3:0] txCount;
        cdf_frz_t lastWord;
        logic [31:0] prdata;
        logic slverr;
    } cdf_ctl_s;

    parameter cdf_ctl_s CDF_CTL_RESET = '{
        data: 1'b1,
        txState: TX_IDLE,
        default: '0
    };

endpackage

//--- hw/cdf_freeze_if.sv
/*
 * Serial freeze link between the controller and the clock device.
 * Assumes both ends run on the same system clock; the controller makes the serial clock.
 */
interface cdf_freeze_if;
    logic freezeClk;
    logic freezeData;

    modport device(
        input freezeClk,
        input freezeData
    );

    modport controller(
        output freezeClk,
        output freezeData
    );
endinterface

//--- hw/cdf_device.sv
/*
 * Digital side of the multi-output clock driver: source selection, output
 * dividers, coincidence marker and glitch-free output freeze.
 * Assumes every clock source arrives as a one-cycle tick on clk_sys, and the
 * serial freeze link is synchronous to clk_sys.
 */
// Our own choices: the placing of the registers and the APB register port.
`include "cdf_map.svh"
module cdf_device (
    input wire logic clk_sys,
    input wire logic rstn,
    cdf_freeze_if.device link,
    input wire logic crystalSelect,
    input wire logic test_input_select,
    input wire logic crystalTick,
    input wire logic test_input_first,
    input wire logic test_input_second,
    input wire logic pllTick,
    input wire logic pllEnable,
    input wire logic oscillator_range_select,
    input wire logic master_reset_output_enable,
    input wire cdf_pkg::cdf_sel2_t bankOneSelect,
    input wire cdf_pkg::cdf_sel2_t bankTwoSelect,
    input wire cdf_pkg::cdf_sel2_t bankThreeSelect,
    input wire cdf_pkg::cdf_sel3_t loop_return_div_select,
    input wire logic invertBankThree,
    output logic [3:0] bank_one_outputs,
    output logic [3:0] bank_two_outputs,
    output logic [3:0] bank_three_outputs,
    output logic loop_return_output,
    output logic coincidence_marker_output,
    output logic outputsFloat,
    output logic pllReferenceTick,
    output cdf_pkg::cdf_frz_t freezeEnableState
);
    import cdf_pkg::*;

    cdf_dev_s s_q;
    cdf_dev_s s_d;

    logic serRise;
    logic refTick;
    logic srcTick;
    logic divTick;
    cdf_cnt_t halfA;
    cdf_cnt_t halfB;
    cdf_cnt_t halfC;
    cdf_cnt_t halfF;
    cdf_cnt_t perA;
    cdf_cnt_t perC;
    cdf_cnt_t perFast;
    cdf_cnt_t perSync;
    logic rawA;
    logic rawB;
    logic rawC;
    logic rawF;
    logic rawMark;
    cdf_frz_t raw;
    cdf_frz_t gated;

    // ==========================================================================
    // Helpers
    function automatic cdf_cnt_t pickHalf(input logic [39:0] tab, input logic [2:0] sel);
        pickHalf = tab[sel*`CDF_HALF_W +: `CDF_HALF_W];
    endfunction

    function automatic cdf_cnt_t stepCnt(input cdf_cnt_t c, input cdf_cnt_t p);
        // Wrap on >= so a select change mid-period cannot run the count away
        stepCnt = ((c + 5'h01) >= p) ? 5'h00 : c + 5'h01;
    endfunction

    function automatic cdf_cnt_t lcmOf(input cdf_cnt_t a, input cdf_cnt_t b);
        int m;
        logic done;
        m = 0;
        done = 1'b0;
        for (int k = 1; k <= `CDF_LCM_STEPS; k++) begin
            if (!done && ((int'(a) * k) % int'(b)) == 0) begin
                m = int'(a) * k;
                done = 1'b1;
            end
        end
        lcmOf = cdf_cnt_t'(m);
    endfunction

    // ==========================================================================
    // Ratio lookup
    always_comb begin
        halfA = pickHalf({20'h00000, `CDF_HALF_A}, {1'b0, bankOneSelect});
        halfB = pickHalf({20'h00000, `CDF_HALF_B}, {1'b0, bankTwoSelect});
        halfC = pickHalf({20'h00000, `CDF_HALF_C}, {1'b0, bankThreeSelect});
        halfF = pickHalf(`CDF_HALF_F, loop_return_div_select);
        perA = cdf_cnt_t'({halfA[3:0], 1'b0});
        perC = cdf_cnt_t'({halfC[3:0], 1'b0});
        perFast = (perA < perC) ? perA : perC;
        perSync = lcmOf(perA, perC);
    end

    // ==========================================================================
    // Next state
    always_comb begin
        s_d = s_q;
        rawA = 1'b0;
        rawB = 1'b0;
        rawC = 1'b0;
        rawF = 1'b0;
        rawMark = 1'b1;
        raw = '0;
        gated = '0;

        // Reference and PLL bypass
        refTick = crystalSelect ? crystalTick
                : (test_input_select ? test_input_second : test_input_first);
        srcTick = pllEnable ? pllTick : refTick;
        s_d.refTick = refTick;
        if (srcTick) begin
            s_d.halfStage = ~s_q.halfStage;
        end
        divTick = srcTick & (oscillator_range_select | s_q.halfStage);

        // Serial freeze port, captured on rising serial clock
        serRise = link.freezeClk & ~s_q.serClkPrev;
        s_d.serClkPrev = link.freezeClk;
        case (s_q.rxState)
            RX_IDLE: begin
                if (serRise && !link.freezeData) begin
                    s_d.rxState = RX_BITS;
                    s_d.rxCount = '0;
                end
            end
            RX_BITS: begin
                if (serRise) begin
                    s_d.rxShift = {link.freezeData, s_q.rxShift[`CDF_FRZ_W-1:1]};
                    s_d.rxCount = s_q.rxCount + 4'h1;
                    if (s_q.rxCount == `CDF_FRZ_LAST) begin
                        s_d.freezeEnable = {link.freezeData, s_q.rxShift[`CDF_FRZ_W-1:1]};
                        s_d.rxState = RX_IDLE;
                    end
                end
            end
            default: begin
                s_d.rxState = RX_IDLE;
            end
        endcase

        s_d.outFloat = ~master_reset_output_enable;
        if (!master_reset_output_enable) begin
            // Held at the aligned starting point until released
            s_d.cntA = '0;
            s_d.cntB = '0;
            s_d.cntC = '0;
            s_d.cntF = '0;
            s_d.cntSync = '0;
            s_d.bankOne = '0;
            s_d.bankTwo = '0;
            s_d.bankThree = '0;
            s_d.loopReturn = 1'b0;
            s_d.marker = 1'b1;
        end else if (divTick) begin
            // Counters never stop for a freeze
            s_d.cntA = stepCnt(s_q.cntA, perA);
            s_d.cntB = stepCnt(s_q.cntB, cdf_cnt_t'({halfB[3:0], 1'b0}));
            s_d.cntC = stepCnt(s_q.cntC, perC);
            s_d.cntF = stepCnt(s_q.cntF, cdf_cnt_t'({halfF[3:0], 1'b0}));
            s_d.cntSync = stepCnt(s_q.cntSync, perSync);
            rawA = s_d.cntA < halfA;
            rawB = s_d.cntB < halfB;
            rawC = s_d.cntC < halfC;
            rawF = s_d.cntF < halfF;
            // Sync count zero is the shared rising edge of banks one and three
            rawMark = ~(s_d.cntSync >= (perSync - perFast));

            raw[`CDF_FRZ_A +: 4] = {4{rawA}};
            raw[`CDF_FRZ_B +: 4] = {4{rawB}};
            raw[`CDF_FRZ_C +: 3] = {{2{rawC ^ invertBankThree}}, rawC};
            raw[`CDF_FRZ_MARK] = rawMark;
            for (int i = 0; i < `CDF_FRZ_W; i++) begin
                // Change freeze state only while the clock is low: no runts
                if (!raw[i]) begin
                    s_d.frozen[i] = ~s_q.freezeEnable[i];
                end
                gated[i] = raw[i] & ~s_d.frozen[i];
            end

            s_d.bankOne = gated[`CDF_FRZ_A +: 4];
            s_d.bankTwo = gated[`CDF_FRZ_B +: 4];
            s_d.bankThree = {gated[`CDF_FRZ_C +: 3], rawC};
            s_d.loopReturn = rawF;
            s_d.marker = gated[`CDF_FRZ_MARK];
        end
    end

    // ==========================================================================
    // State register; reset leaves every divider at phase zero
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_q <= CDF_DEV_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================================
    // Outputs
    assign bank_one_outputs = s_q.bankOne;
    assign bank_two_outputs = s_q.bankTwo;
    assign bank_three_outputs = s_q.bankThree;
    assign loop_return_output = s_q.loopReturn;
    assign coincidence_marker_output = s_q.marker;
    assign outputsFloat = s_q.outFloat;
    assign pllReferenceTick = s_q.refTick;
    assign freezeEnableState = s_q.freezeEnable;

endmodule

//--- hw/cdf_controller.sv
/*
 * Freeze controller: takes a freeze word over APB and sends it on the serial
 * freeze link with a free-running serial clock divided from clk_sys.
 * Assumes an APB master on the same clock; the slave never waits.
 */
`include "cdf_map.svh"
module cdf_controller #(
    parameter logic [7:0] SER_HALF = `CDF_SER_HALF
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    cdf_freeze_if.controller link
);
    import cdf_pkg::*;

    cdf_ctl_s s_q;
    cdf_ctl_s s_d;
    logic toggle;
    logic fall;
    logic busy;
    logic hitWord;
    logic hitStat;

    // ==========================================================================
    // Next state
    always_comb begin
        s_d = s_q;
        busy = s_q.txState != TX_IDLE;
        hitWord = paddr == `CDF_ADDR_WORD;
        hitStat = paddr == `CDF_ADDR_STAT;

        // Free-running serial clock; data changes on its falling edge
        toggle = s_q.divCnt == (SER_HALF - 8'h01);
        s_d.divCnt = toggle ? 8'h00 : s_q.divCnt + 8'h01;
        if (toggle) begin
            s_d.serClk = ~s_q.serClk;
        end
        fall = toggle & s_q.serClk;

        // Answer prepared in the setup cycle, shown in the access phase
        if (psel && !penable) begin
            s_d.prdata = '0;
            s_d.prdata[`CDF_STAT_BUSY] = busy;
            s_d.prdata[`CDF_STAT_WORD +: `CDF_FRZ_W] = s_q.lastWord;
            s_d.slverr = !(hitWord || hitStat) || (pwrite && hitWord && busy) || (pwrite && hitStat);
        end

        if (psel && penable && pwrite && hitWord && !busy) begin
            s_d.txShift = pwdata[`CDF_FRZ_W-1:0];
            s_d.lastWord = pwdata[`CDF_FRZ_W-1:0];
            s_d.txState = TX_START;
        end

        if (fall) begin
            case (s_q.txState)
                TX_IDLE: begin
                    s_d.data = 1'b1;
                end
                TX_START: begin
                    s_d.data = 1'b0;
                    s_d.txCount = '0;
                    s_d.txState = TX_BITS;
                end
                TX_BITS: begin
                    if (s_q.txCount == `CDF_TX_DONE) begin
                        s_d.data = 1'b1;
                        s_d.txState = TX_IDLE;
                    end else begin
                        s_d.data = s_q.txShift[0];
                        s_d.txShift = {1'b0, s_q.txShift[`CDF_FRZ_W-1:1]};
                        s_d.txCount = s_q.txCount + 4'h1;
                    end
                end
                default: begin
                    s_d.txState = TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_q <= CDF_CTL_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================================
    // Outputs
    assign pready = 1'b1;
    assign prdata = s_q.prdata;
    assign pslverr = s_q.slverr;
    assign link.freezeClk = s_q.serClk;
    assign link.freezeData = s_q.data;

endmodule

//--- testbench/cdf_link_sva.sv
/*
 * Checker on the serial freeze link between controller and device.
 * Assumes the link is sampled on clk_sys and the serial half period is SER_HALF cycles.
 */
module cdf_link_sva #(
    parameter logic [7:0] SER_HALF = 8'h04
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic freezeClk,
    input wire logic freezeData
);
    // Start bit to return of idle spans 13 serial periods
    localparam int FRAME_IN = 26 * SER_HALF - 1;
    logic clkPrev_q, started_q, inFrame_q;
    logic [7:0] runLen_q;
    logic [3:0] fallCnt_q;
    wire logic toggle = freezeClk != clkPrev_q;
    wire logic fallNow = clkPrev_q && !freezeClk;

    // ==========================================================================
    // Helper logic: half period length and frame position
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            clkPrev_q <= 1'b0;
            started_q <= 1'b0;
            inFrame_q <= 1'b0;
            runLen_q <= 8'h00;
            fallCnt_q <= 4'h0;
        end else begin
            clkPrev_q <= freezeClk;
            started_q <= started_q | toggle;
            runLen_q <= toggle ? 8'h00 : runLen_q + 8'h01;
            if (fallNow && !inFrame_q && !freezeData) begin
                inFrame_q <= 1'b1;
                fallCnt_q <= 4'h0;
            end else if (fallNow && inFrame_q) begin
                fallCnt_q <= fallCnt_q + 4'h1;
                inFrame_q <= fallCnt_q != 4'hc;
            end
        end
    end

    // ==========================================================================
    // Assertions
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_clk_half_period: assert property (started_q && toggle |-> runLen_q == SER_HALF - 8'h01)
        else $error("serial clock half period wrong");
    a_clk_free_run: assert property (started_q |-> runLen_q < SER_HALF)
        else $error("serial clock stopped");
    a_data_on_fall: assert property ($changed(freezeData) |-> fallNow)
        else $error("serial data changed away from a falling serial clock");
    a_data_setup: assert property ($rose(freezeClk) |-> $stable(freezeData))
        else $error("serial data moved at the capture edge");
    a_idle_high: assert property (!inFrame_q && !fallNow |-> freezeData)
        else $error("serial data low outside a frame");
    a_stop_high: assert property (inFrame_q && fallNow && fallCnt_q == 4'hc |-> freezeData)
        else $error("more than twelve bits after start");
    a_frame_len: assert property ($rose(inFrame_q) |-> (inFrame_q throughout ##[FRAME_IN:FRAME_IN] 1'b1) ##1 !inFrame_q)
        else $error("frame length wrong");
    a_reset_quiet: assert property ($rose(rstn) |-> freezeData && !freezeClk)
        else $error("link not idle after reset");
endmodule

//--- testbench/clock_divider_freeze_control_test.sv
/*
 * Self-checking bench: controller and clock device joined by the freeze link.
 * Assumes clock sources are one-cycle ticks on clk_sys and the controller answers APB at once.
 */
module clock_divider_freeze_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    import cdf_pkg::*;
    logic clk_sys = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic crystalSelect = 1, test_input_select = 0, crystalTick = 1, test_input_first = 0, test_input_second = 0;
    logic pllTick = 0, pllEnable = 0, oscillator_range_select = 1, master_reset_output_enable = 1, invertBankThree = 0;
    cdf_sel2_t bankOneSelect = '0, bankTwoSelect = '0, bankThreeSelect = '0;
    cdf_sel3_t loop_return_div_select = '0;
    logic [3:0] bank_one_outputs, bank_two_outputs, bank_three_outputs;
    logic loop_return_output, coincidence_marker_output, outputsFloat, pllReferenceTick;
    cdf_frz_t freezeEnableState, wireWord;
    int mismatches = 0, check_count = 0;
    cdf_freeze_if link();
    cdf_controller #(.SER_HALF(8'h04)) i_cdf_controller (.clk_sys, .rstn, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .link(link));
    cdf_device i_cdf_device (.clk_sys, .rstn, .link(link), .crystalSelect, .test_input_select, .crystalTick,
        .test_input_first, .test_input_second, .pllTick, .pllEnable, .oscillator_range_select,
        .master_reset_output_enable, .bankOneSelect, .bankTwoSelect, .bankThreeSelect, .loop_return_div_select,
        .invertBankThree, .bank_one_outputs, .bank_two_outputs, .bank_three_outputs, .loop_return_output,
        .coincidence_marker_output, .outputsFloat, .pllReferenceTick, .freezeEnableState);
    cdf_link_sva #(.SER_HALF(8'h04)) i_cdf_link_sva (.clk_sys, .rstn, .freezeClk(link.freezeClk),
        .freezeData(link.freezeData));

    always #5 clk_sys = ~clk_sys;

    // ==========================================================================
    // Wire monitor: start bit then twelve bits, first bit lowest
    initial forever begin
        @(posedge link.freezeClk);
        if (link.freezeData === 1'b0) begin
            for (int i = 0; i < 12; i++) begin
                @(posedge link.freezeClk);
                wireWord[i] = link.freezeData;
            end
        end
    end

    // ==========================================================================
    // Shared tasks
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [13:0] outs();
        return {loop_return_output, bank_three_outputs[0], coincidence_marker_output, bank_three_outputs[3:1],
            bank_two_outputs, bank_one_outputs};
    endfunction

    function automatic logic sig(int k);
        logic [3:0] v;
        v = {loop_return_output, bank_three_outputs[0], bank_two_outputs[0], bank_one_outputs[0]};
        return v[k];
    endfunction

    // Counts cycles up to the next rising edge of output k
    task automatic rise(input int k, output int n);
        logic p;
        p = sig(k);
        n = 0;
        repeat (100) begin
            @(negedge clk_sys);
            n++;
            if (sig(k) === 1'b1 && p === 1'b0) break;
            p = sig(k);
        end
    endtask

    task automatic send(input cdf_frz_t w);
        logic [31:0] r;
        logic e;
        apb(12'h000, 1'b1, {20'h0, w}, r, e);
        check("write error", e, 1'b0);
        apb(12'h000, 1'b1, 32'h0, r, e);
        check("busy write error", e, 1'b1);
        repeat (100) begin
            apb(12'h004, 1'b0, 32'h0, r, e);
            if (r[0] === 1'b0) break;
        end
        repeat (4) @(negedge clk_sys);
        check("freeze state", freezeEnableState, w);
        check("wire word", wireWord, w);
        check("status word", r[27:16], w);
    endtask

    // Master reset pulse realigns every divider after select changes
    task automatic realign();
        @(posedge clk_sys);
        master_reset_output_enable <= 1'b0;
        repeat (3) @(negedge clk_sys);
        check("float in reset", outputsFloat, 1'b1);
        check("outputs in reset", outs(), 14'h0800);
        @(posedge clk_sys);
        master_reset_output_enable <= 1'b1;
        repeat (3) @(negedge clk_sys);
        check("float after reset", outputsFloat, 1'b0);
    endtask

    // ==========================================================================
    // Scenarios
    task automatic t_freeze();
        logic [13:0] hi;
        logic bad;
        check("freeze reset", freezeEnableState, 12'hfff);
        for (int i = 0; i < 13; i++) begin
            send(i < 12 ? 12'hfff ^ (12'h001 << i) : 12'h000);
            hi = '0;
            repeat (24) begin
                @(negedge clk_sys);
                hi |= outs();
            end
            check("frozen set", 14'(~hi), i < 12 ? 14'h0001 << i : 14'h0fff);
        end
        send(12'hfff);
        bad = 0;
        repeat (8) @(negedge clk_sys);
        repeat (24) begin
            @(negedge clk_sys);
            bad |= {bank_two_outputs, bank_one_outputs} !== {8{loop_return_output}};
        end
        check("restart in phase", bad, 1'b0);
        $display("freeze test done");
    endtask

    task automatic t_dividers();
        int n;
        int t[4][8] = '{'{4, 6, 8, 12, 4, 6, 8, 12}, '{4, 6, 8, 10, 4, 6, 8, 10}, '{2, 4, 6, 8, 2, 4, 6, 8},
            '{4, 6, 8, 10, 8, 12, 16, 20}};
        for (int r = 1; r >= 0; r--) begin
            for (int s = 0; s < 8; s++) begin
                @(posedge clk_sys);
                oscillator_range_select <= r[0];
                {bankOneSelect, bankTwoSelect, bankThreeSelect} <= {3{s[1:0]}};
                loop_return_div_select <= s[2:0];
                for (int k = 0; k < 4; k++) begin
                    rise(k, n);
                    rise(k, n);
                    check("divider period", n, t[k][s] * (2 - r));
                end
            end
        end
        $display("divider test done");
    endtask

    task automatic t_invert();
        @(posedge clk_sys);
        bankThreeSelect <= 2'b01;
        for (int v = 0; v < 2; v++) begin
            @(posedge clk_sys);
            invertBankThree <= v[0];
            repeat (2) @(negedge clk_sys);
            repeat (8) begin
                @(negedge clk_sys);
                check("inverted pair", bank_three_outputs[3:2], bank_three_outputs[1:0] ^ {2{v[0]}});
            end
        end
        $display("invert test done");
    endtask

    task automatic t_marker();
        int lows;
        logic pm, pa, pc;
        logic [1:0] sa[3] = '{2'b01, 2'b11, 2'b01};
        logic [1:0] sc[3] = '{2'b00, 2'b10, 2'b11};
        int want[3] = '{16, 24, 12};
        for (int i = 0; i < 3; i++) begin
            while (coincidence_marker_output !== 1'b0) @(posedge clk_sys);
            @(posedge clk_sys);
            bankOneSelect <= sa[i];
            bankThreeSelect <= sc[i];
            realign();
            lows = 0;
            {pm, pa, pc} = {coincidence_marker_output, bank_one_outputs[0], bank_three_outputs[0]};
            repeat (48) begin
                @(negedge clk_sys);
                lows += !coincidence_marker_output;
                if (coincidence_marker_output && !pm)
                    check("coincident rise", {pa, bank_one_outputs[0], pc, bank_three_outputs[0]}, 4'h5);
                {pm, pa, pc} = {coincidence_marker_output, bank_one_outputs[0], bank_three_outputs[0]};
            end
            check("marker low cycles", lows, want[i]);
        end
        $display("marker test done");
    endtask

    task automatic t_source();
        logic [2:0] cfg[4] = '{3'b010, 3'b000, 3'b001, 3'b100};
        logic wantTick[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        logic p;
        int n;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            {crystalSelect, test_input_select, crystalTick} <= cfg[i];
            {test_input_first, test_input_second} <= {i[1], !i[1]};
            repeat (3) @(negedge clk_sys);
            check("reference tick", pllReferenceTick, wantTick[i]);
        end
        for (int v = 0; v < 2; v++) begin
            @(posedge clk_sys);
            {crystalTick, pllEnable, pllTick} <= {2'b11, v[0]};
            {oscillator_range_select, bankThreeSelect} <= 3'b100;
            repeat (3) @(negedge clk_sys);
            n = 0;
            p = bank_three_outputs[0];
            repeat (16) begin
                @(negedge clk_sys);
                n += bank_three_outputs[0] !== p;
                p = bank_three_outputs[0];
            end
            check("pll clocked toggles", n, v * 16);
        end
        $display("source test done");
    endtask

    task automatic t_regs();
        logic [31:0] r;
        logic e;
        apb(12'h008, 1'b0, 32'h0, r, e);
        check("unmapped error", e, 1'b1);
        apb(12'h004, 1'b1, 32'h0, r, e);
        check("status write error", e, 1'b1);
        $display("register test done");
    endtask

    initial begin
        #400000;
        mismatches++;
        summarize();
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (2) @(negedge clk_sys);
        t_freeze();
        t_dividers();
        t_invert();
        t_marker();
        t_source();
        t_regs();
        summarize();
    end
endmodule
